// [src/sps_sequencer.sv]
// sensor power save sequencer with AXI4-Lite registers
//
// Our own choices: the address map and the AXI4-Lite slave port.
module sps_sequencer #(
	parameter int unsigned TICK_CYCLES = sps_pkg::TICK_CYCLES_DEF
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic sampleDone,
	input wire logic linkDetect,
	input wire logic setupButton,
	output logic sampleStart_q,
	output logic sensorRailEn_q,
	output logic slowClkSel_q,
	output logic ethPowerDown_q
);
	localparam int TW = sps_pkg::TIME_W;

	// byte-lane merge of a write into a narrow register
	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		logic [15:0] r;
		r = old;
		if (strb[0])
			r[7:0] = data[7:0];
		if (strb[1])
			r[15:8] = data[15:8];
		return r;
	endfunction : merge16

	// interval counter has reached its limit in ticks
	function automatic logic reached(input logic [15:0] cnt,
		input logic [15:0] lim);
		return cnt >= lim;
	endfunction : reached

	sps_pkg::sps_supply_t mode_q;
	sps_pkg::sps_phase_t phase_q;
	logic lowPower_q;
	logic apdEn_q;
	logic [TW-1:0] sleep_q;
	logic [TW-1:0] warm_q;
	logic [TW-1:0] phaseCnt_q;
	logic [TW-1:0] probeCnt_q;
	logic setupPrev_q;
	logic awHave_q;
	logic wHave_q;
	logic [7:0] awAddr_q;
	logic [31:0] wData_q;
	logic [3:0] wStrb_q;
	logic phaseTick;
	logic freeTick;
	logic phaseChange;
	logic [TW-1:0] warmLim;
	logic doWrite;
	logic probeActive;

	// ---- AXI4-Lite write side
	assign doWrite = awHave_q && wHave_q && !s_axi_bvalid;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			s_axi_awready <= 1'b0;
		else if (s_axi_awvalid && s_axi_awready)
			s_axi_awready <= 1'b0;
		else if (!awHave_q && !s_axi_bvalid)
			s_axi_awready <= 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			s_axi_wready <= 1'b0;
		else if (s_axi_wvalid && s_axi_wready)
			s_axi_wready <= 1'b0;
		else if (!wHave_q && !s_axi_bvalid)
			s_axi_wready <= 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			awHave_q <= 1'b0;
			awAddr_q <= 8'h00;
		end
		else if (s_axi_awvalid && s_axi_awready)
		begin
			awHave_q <= 1'b1;
			awAddr_q <= s_axi_awaddr;
		end
		else if (doWrite)
			awHave_q <= 1'b0;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			wHave_q <= 1'b0;
			wData_q <= 32'h0000_0000;
			wStrb_q <= 4'h0;
		end
		else if (s_axi_wvalid && s_axi_wready)
		begin
			wHave_q <= 1'b1;
			wData_q <= s_axi_wdata;
			wStrb_q <= s_axi_wstrb;
		end
		else if (doWrite)
			wHave_q <= 1'b0;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= sps_pkg::AXI_OKAY;
		end
		else if (doWrite)
		begin
			s_axi_bvalid <= 1'b1;
			if (awAddr_q == sps_pkg::CTRL_OFS ||
				awAddr_q == sps_pkg::SLEEP_OFS ||
				awAddr_q == sps_pkg::WARM_OFS ||
				awAddr_q == sps_pkg::STATUS_OFS)
				s_axi_bresp <= sps_pkg::AXI_OKAY;
			else
				s_axi_bresp <= sps_pkg::AXI_SLVERR;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// ---- configuration registers
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			mode_q <= sps_pkg::MODE_RST;
			lowPower_q <= 1'b0;
			apdEn_q <= 1'b0;
		end
		else if (doWrite && awAddr_q == sps_pkg::CTRL_OFS && wStrb_q[0])
		begin
			// the unused fourth code is dropped, old setting kept
			if (wData_q[sps_pkg::CTRL_MODE_LSB +: 2] != 2'b11)
				mode_q <= sps_pkg::sps_supply_t'(
					wData_q[sps_pkg::CTRL_MODE_LSB +: 2]);
			lowPower_q <= wData_q[sps_pkg::CTRL_LOWPWR_BIT];
			apdEn_q <= wData_q[sps_pkg::CTRL_APD_BIT];
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			sleep_q <= sps_pkg::SLEEP_RST;
			warm_q <= sps_pkg::WARM_RST;
		end
		else if (doWrite && awAddr_q == sps_pkg::SLEEP_OFS)
			sleep_q <= merge16(sleep_q, wData_q, wStrb_q);
		else if (doWrite && awAddr_q == sps_pkg::WARM_OFS)
			warm_q <= merge16(warm_q, wData_q, wStrb_q);
	end

	// ---- AXI4-Lite read side
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			s_axi_arready <= 1'b0;
		else if (s_axi_arvalid && s_axi_arready)
			s_axi_arready <= 1'b0;
		else if (!s_axi_rvalid)
			s_axi_arready <= 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= sps_pkg::AXI_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= sps_pkg::AXI_OKAY;
			s_axi_rdata <= 32'h0000_0000;
			if (s_axi_araddr == sps_pkg::CTRL_OFS)
			begin
				s_axi_rdata[sps_pkg::CTRL_MODE_LSB +: 2] <= mode_q;
				s_axi_rdata[sps_pkg::CTRL_LOWPWR_BIT] <= lowPower_q;
				s_axi_rdata[sps_pkg::CTRL_APD_BIT] <= apdEn_q;
			end
			else if (s_axi_araddr == sps_pkg::SLEEP_OFS)
				s_axi_rdata[TW-1:0] <= sleep_q;
			else if (s_axi_araddr == sps_pkg::WARM_OFS)
				s_axi_rdata[TW-1:0] <= warm_q;
			else if (s_axi_araddr == sps_pkg::STATUS_OFS)
			begin
				s_axi_rdata[sps_pkg::STAT_PHASE_LSB +: 2] <= phase_q;
				s_axi_rdata[sps_pkg::STAT_RAIL_BIT] <= sensorRailEn_q;
				s_axi_rdata[sps_pkg::STAT_SLOW_BIT] <= slowClkSel_q;
				s_axi_rdata[sps_pkg::STAT_ETHDN_BIT] <= ethPowerDown_q;
				s_axi_rdata[sps_pkg::STAT_PROBE_BIT] <= probeActive;
			end
			else
				s_axi_rresp <= sps_pkg::AXI_SLVERR;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// ---- sampling sequence
	// restarting the divider on each phase entry keeps intervals exact
	sps_tick #(.TICK_CYCLES(TICK_CYCLES)) u_phaseTick (
		.clk(clk),
		.rst_n(rst_n),
		.restart(phaseChange),
		.tick_q(phaseTick)
	);

	// warm-up only counts in the switched setting, even when a zero sleep left the rail on
	assign warmLim = (mode_q == sps_pkg::SUPPLY_SWITCHED) ? warm_q : '0;

	always_comb
	begin
		phaseChange = 1'b0;
		case (phase_q)
			sps_pkg::PH_WARM:
				phaseChange = reached(phaseCnt_q, warmLim);
			sps_pkg::PH_SAMPLE:
				phaseChange = sampleDone && !sampleStart_q;
			sps_pkg::PH_SLEEP:
				phaseChange = reached(phaseCnt_q, sleep_q);
			default:
				phaseChange = 1'b1;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			phase_q <= sps_pkg::PH_WARM;
		else if (phaseChange)
		begin
			case (phase_q)
				sps_pkg::PH_WARM:
					phase_q <= sps_pkg::PH_SAMPLE;
				sps_pkg::PH_SAMPLE:
					if (sleep_q == '0)
						phase_q <= sps_pkg::PH_WARM;
					else
						phase_q <= sps_pkg::PH_SLEEP;
				default:
					phase_q <= sps_pkg::PH_WARM;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n || phaseChange)
			phaseCnt_q <= '0;
		else if (phaseTick && phaseCnt_q != '1)
			phaseCnt_q <= phaseCnt_q + TW'(1);
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			sampleStart_q <= 1'b0;
		else
			sampleStart_q <= phaseChange && phase_q == sps_pkg::PH_WARM;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			sensorRailEn_q <= 1'b0;
		else
			case (mode_q)
				sps_pkg::SUPPLY_ON:
					sensorRailEn_q <= 1'b1;
				sps_pkg::SUPPLY_SWITCHED:
					sensorRailEn_q <= phase_q != sps_pkg::PH_SLEEP;
				default:
					sensorRailEn_q <= 1'b0;
			endcase
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			slowClkSel_q <= 1'b0;
		else
			slowClkSel_q <= lowPower_q;
	end

	// ---- Ethernet auto power down
	sps_tick #(.TICK_CYCLES(TICK_CYCLES)) u_freeTick (
		.clk(clk),
		.rst_n(rst_n),
		.restart(1'b0),
		.tick_q(freeTick)
	);

	assign probeActive = probeCnt_q != '0;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			probeCnt_q <= sps_pkg::PROBE_TICKS;
			setupPrev_q <= 1'b0;
		end
		else
		begin
			setupPrev_q <= setupButton;
			if (setupButton && !setupPrev_q)
				probeCnt_q <= sps_pkg::PROBE_TICKS;
			else if (freeTick && probeCnt_q != '0)
				probeCnt_q <= probeCnt_q - TW'(1);
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			ethPowerDown_q <= 1'b0;
		else
			ethPowerDown_q <= apdEn_q && !linkDetect && !probeActive;
	end

	// ---- checks
	a_rail_always_on: assert property (@(posedge clk) disable iff (!rst_n)
		mode_q == sps_pkg::SUPPLY_ON |=> sensorRailEn_q)
		else $error("rail not on under always-on setting");
	a_rail_kept_off: assert property (@(posedge clk) disable iff (!rst_n)
		mode_q == sps_pkg::SUPPLY_OFF |=> !sensorRailEn_q)
		else $error("rail on under off setting");
	a_sleep_rail_off: assert property (@(posedge clk) disable iff (!rst_n)
		mode_q == sps_pkg::SUPPLY_SWITCHED && phase_q == sps_pkg::PH_SLEEP
		|=> !sensorRailEn_q)
		else $error("rail on during switched sleep");
	a_read_rail_on: assert property (@(posedge clk) disable iff (!rst_n)
		mode_q == sps_pkg::SUPPLY_SWITCHED && phase_q != sps_pkg::PH_SLEEP
		|=> sensorRailEn_q)
		else $error("rail off while warming or reading");
	a_warm_first: assert property (@(posedge clk) disable iff (!rst_n)
		// judged by the setting in force when the warm phase ended
		sampleStart_q && $past(mode_q) == sps_pkg::SUPPLY_SWITCHED &&
		$past(warm_q) != '0
		|-> $past(phaseCnt_q) >= $past(warm_q) && sensorRailEn_q)
		else $error("sample started before warm-up elapsed");
	a_sleep_entry: assert property (@(posedge clk) disable iff (!rst_n)
		phase_q == sps_pkg::PH_SAMPLE && phaseChange && sleep_q != '0
		|=> phase_q == sps_pkg::PH_SLEEP ##1 !sampleStart_q)
		else $error("no sleep after sample");
	a_zero_sleep: assert property (@(posedge clk) disable iff (!rst_n)
		phase_q == sps_pkg::PH_SAMPLE && phaseChange && sleep_q == '0
		|=> phase_q == sps_pkg::PH_WARM)
		else $error("zero sleep still slept");
	a_slow_clock: assert property (@(posedge clk) disable iff (!rst_n)
		##1 slowClkSel_q == $past(lowPower_q))
		else $error("slow clock select does not follow setting");
	a_eth_sleeps: assert property (@(posedge clk) disable iff (!rst_n)
		apdEn_q && !linkDetect && probeCnt_q == '0 |=> ethPowerDown_q)
		else $error("unlinked Ethernet not put to sleep");
	a_eth_wakes: assert property (@(posedge clk) disable iff (!rst_n)
		linkDetect |=> !ethPowerDown_q)
		else $error("Ethernet asleep with link present");
	a_eth_probe: assert property (@(posedge clk) disable iff (!rst_n)
		setupButton && !setupPrev_q |=> ##1 !ethPowerDown_q [*2])
		else $error("setup press did not wake Ethernet");
	a_bad_mode: assert property (@(posedge clk) disable iff (!rst_n)
		##1 mode_q != 2'b11)
		else $error("unsupported supply setting stored");

	c_switched_sample: cover property (@(posedge clk) disable iff (!rst_n)
		sampleStart_q && mode_q == sps_pkg::SUPPLY_SWITCHED);
	c_sleep_done: cover property (@(posedge clk) disable iff (!rst_n)
		phase_q == sps_pkg::PH_SLEEP && phaseChange);
	c_eth_down: cover property (@(posedge clk) disable iff (!rst_n)
		$rose(ethPowerDown_q));
	c_setup_probe: cover property (@(posedge clk) disable iff (!rst_n)
		setupButton && !setupPrev_q && apdEn_q);
endmodule : sps_sequencer

// [common/sps_pkg.sv]
// constants and types of the sensor power save sequencer
// Notes on behaviour
// - sleep interval spaces analog samples
// - switched mode: rail off while sleeping
// - supply setting only on, switched, off
// - on setting keeps rail energized always
// - off setting keeps rail disabled always
// - switched rail on only for warm-up, reading
// - switched mode: rail on for warm-up before sampling
// - low power setting selects slow clock
// - auto power down sleeps unlinked Ethernet
// - link reconnect wakes sleeping Ethernet
// - power-up and setup button briefly wake Ethernet
package sps_pkg;
	// register byte offsets
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] SLEEP_OFS = 8'h04;
	localparam logic [7:0] WARM_OFS = 8'h08;
	localparam logic [7:0] STATUS_OFS = 8'h0C;
	// control field positions
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_LOWPWR_BIT = 2;
	localparam int CTRL_APD_BIT = 3;
	// status field positions
	localparam int STAT_PHASE_LSB = 0;
	localparam int STAT_RAIL_BIT = 2;
	localparam int STAT_SLOW_BIT = 3;
	localparam int STAT_ETHDN_BIT = 4;
	localparam int STAT_PROBE_BIT = 5;
	// times are held in tenths of a second
	localparam int TIME_W = 16;
	localparam logic [15:0] SLEEP_RST = 16'h0000;
	localparam logic [15:0] WARM_RST = 16'h0001;
	localparam int TICK_MS = 100;
	localparam int CLK_PERIOD_NS = 20;
	localparam int TICK_CYCLES_DEF = TICK_MS * 1000000 / CLK_PERIOD_NS;
	localparam int PROBE_MS = 2000;
	localparam logic [15:0] PROBE_TICKS = 16'(PROBE_MS / TICK_MS);
	localparam logic [1:0] AXI_OKAY = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;

	typedef enum logic [1:0]
	{
		SUPPLY_ON = 2'b00,
		SUPPLY_SWITCHED = 2'b01,
		SUPPLY_OFF = 2'b10
	} sps_supply_t;

	typedef enum logic [1:0]
	{
		PH_WARM = 2'b00,
		PH_SAMPLE = 2'b01,
		PH_SLEEP = 2'b10
	} sps_phase_t;

	localparam sps_supply_t MODE_RST = SUPPLY_ON;
endpackage : sps_pkg

// [src/sps_tick.sv]
// tenth-of-a-second tick divider with restart
module sps_tick #(
	parameter int unsigned TICK_CYCLES = 5000000
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic restart,
	output logic tick_q
);
	localparam int CW = $clog2(TICK_CYCLES);
	localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

	if (TICK_CYCLES < 2)
	begin : g_chk
		$error("sps_tick: TICK_CYCLES must be at least 2");
	end

	logic [CW-1:0] cnt_q;

	always_ff @(posedge clk)
	begin
		if (!rst_n || restart)
			cnt_q <= '0;
		else if (cnt_q == LAST)
			cnt_q <= '0;
		else
			cnt_q <= cnt_q + CW'(1);
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n || restart)
			tick_q <= 1'b0;
		else
			tick_q <= (cnt_q == LAST);
	end

	a_tick_period: assert property (@(posedge clk) disable iff (!rst_n)
		tick_q |=> !tick_q)
		else $error("tick lasted more than one cycle");
endmodule : sps_tick

// [sim/sps_sensor_model.sv]
// far-side model: the converter answers each sample start after a delay
module sps_sensor_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sampleStart,
	input wire logic [3:0] delay,
	output logic sampleDone
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt = 4'h0;
	initial sampleDone = 1'b0;
	// delay is set per scenario, so both prompt and slow answers are seen
	always @(posedge clk)
	begin
		sampleDone <= rst_n && !sampleStart && cnt == 4'h1;
		if (!rst_n)
			cnt <= 4'h0;
		else if (sampleStart)
			cnt <= delay;
		else if (cnt != 4'h0)
			cnt <= cnt - 4'h1;
	end
endmodule : sps_sensor_model

// [sim/sps_sequencer_tb.sv]
// self-checking testbench of the sensor power save sequencer
module sps_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TC = 4;
	localparam logic [1:0] OK = sps_pkg::AXI_OKAY;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] awAddr = 8'h00;
	logic [7:0] arAddr = 8'h00;
	logic [31:0] wData = 32'h0;
	logic awValid = 1'b0;
	logic wValid = 1'b0;
	logic bReady = 1'b0;
	logic arValid = 1'b0;
	logic rReady = 1'b0;
	logic linkDetect = 1'b0;
	logic setupButton = 1'b0;
	logic [3:0] sensorDelay = 4'h3;
	logic awReady, wReady, bValid, arReady, rValid, sampleDone;
	logic [1:0] bResp, rResp;
	logic [31:0] rData;
	wire [3:0] outs;
	int n_fail = 0;
	int check_count = 0;
	int cyc;

	always #10 clk = ~clk;

	sps_sequencer #(.TICK_CYCLES(TC)) sps_sequencer_i (
		.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awAddr),
		.s_axi_awvalid(awValid), .s_axi_awready(awReady),
		.s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid),
		.s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
		.s_axi_bready(bReady), .s_axi_araddr(arAddr),
		.s_axi_arvalid(arValid), .s_axi_arready(arReady),
		.s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
		.s_axi_rready(rReady), .sampleDone(sampleDone),
		.linkDetect(linkDetect), .setupButton(setupButton),
		.sampleStart_q(outs[0]), .sensorRailEn_q(outs[1]),
		.slowClkSel_q(outs[2]), .ethPowerDown_q(outs[3]));

	sps_sensor_model sps_sensor_model_i (.clk(clk), .rst_n(rst_n),
		.sampleStart(outs[0]), .delay(sensorDelay), .sampleDone(sampleDone));

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// readies are registered, so the negedge value is what the edge sees
	task automatic axiWrite(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		bit ta, tw, tb;
		@(posedge clk);
		awAddr <= a;
		wData <= d;
		awValid <= 1'b1;
		wValid <= 1'b1;
		bReady <= 1'b1;
		tb = 0;
		for (int n = 0; n < 100 && !tb; n++)
		begin
			@(negedge clk);
			ta = awValid && awReady;
			tw = wValid && wReady;
			tb = bValid;
			if (tb)
				chk(bResp, er);
			@(posedge clk);
			if (ta)
				awValid <= 1'b0;
			if (tw)
				wValid <= 1'b0;
			if (tb)
				bReady <= 1'b0;
		end
		chk(tb, 1'b1);
	endtask : axiWrite

	task automatic axiRead(input logic [7:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		bit ta, tr;
		@(posedge clk);
		arAddr <= a;
		arValid <= 1'b1;
		rReady <= 1'b1;
		tr = 0;
		for (int n = 0; n < 100 && !tr; n++)
		begin
			@(negedge clk);
			ta = arValid && arReady;
			tr = rValid;
			if (tr)
			begin
				chk(rData, ed);
				chk(rResp, er);
			end
			@(posedge clk);
			if (ta)
				arValid <= 1'b0;
			if (tr)
				rReady <= 1'b0;
		end
		chk(tr, 1'b1);
	endtask : axiRead

	// returns cycles waited; above lim means the level never came
	task automatic waitOut(input int i, input logic v, input int lim,
		output int c);
		c = 0;
		while (outs[i] !== v && c <= lim)
		begin
			@(negedge clk);
			c++;
		end
	endtask : waitOut

	task automatic scReset();
		axiRead(sps_pkg::CTRL_OFS, 32'h0, OK);
		axiRead(sps_pkg::SLEEP_OFS, 32'h0, OK);
		axiRead(sps_pkg::WARM_OFS, 32'h1, OK);
		axiRead(8'h10, 32'h0, sps_pkg::AXI_SLVERR);
		axiWrite(8'h10, 32'h5, sps_pkg::AXI_SLVERR);
		chk(outs[1], 1'b1);
		axiWrite(sps_pkg::CTRL_OFS, 32'h8, OK);
		chk(outs[3], 1'b0);
		waitOut(3, 1'b1, 120, cyc);
		chk(outs[3], 1'b1);
	endtask : scReset

	task automatic scModes();
		axiWrite(sps_pkg::CTRL_OFS, 32'h2, OK);
		waitOut(1, 1'b0, 3, cyc);
		chk(cyc <= 3, 1);
		waitOut(1, 1'b1, 40, cyc);
		chk(cyc > 40, 1);
		axiWrite(sps_pkg::CTRL_OFS, 32'h3, OK);
		axiRead(sps_pkg::CTRL_OFS, 32'h2, OK);
		axiWrite(sps_pkg::CTRL_OFS, 32'h0, OK);
		waitOut(1, 1'b1, 3, cyc);
		chk(cyc <= 3, 1);
		waitOut(1, 1'b0, 40, cyc);
		chk(cyc > 40, 1);
	endtask : scModes

	task automatic scSwitched();
		axiWrite(sps_pkg::SLEEP_OFS, 32'h2, OK);
		axiWrite(sps_pkg::CTRL_OFS, 32'h1, OK);
		waitOut(0, 1'b1, 200, cyc);
		chk(cyc <= 200, 1);
		waitOut(1, 1'b0, 20, cyc);
		chk(cyc <= 20, 1);
		waitOut(1, 1'b1, 100, cyc);
		chk(cyc >= 2 * TC && cyc <= 2 * TC + 4, 1);
		waitOut(0, 1'b1, 100, cyc);
		chk(cyc >= TC && cyc <= TC + 4, 1);
	endtask : scSwitched

	task automatic scNoSleep();
		@(posedge clk);
		sensorDelay <= 4'h9;
		axiWrite(sps_pkg::SLEEP_OFS, 32'h0, OK);
		waitOut(0, 1'b1, 200, cyc);
		waitOut(0, 1'b0, 2, cyc);
		waitOut(0, 1'b1, 40, cyc);
		chk(cyc >= 9 && cyc <= 9 + TC + 6, 1);
		waitOut(1, 1'b0, 30, cyc);
		chk(cyc > 30, 1);
	endtask : scNoSleep

	task automatic scLowPower();
		axiWrite(sps_pkg::CTRL_OFS, 32'h5, OK);
		waitOut(2, 1'b1, 3, cyc);
		chk(outs[2], 1'b1);
		axiWrite(sps_pkg::CTRL_OFS, 32'h1, OK);
		waitOut(2, 1'b0, 3, cyc);
		chk(outs[2], 1'b0);
	endtask : scLowPower

	task automatic scEthernet();
		axiWrite(sps_pkg::CTRL_OFS, 32'h9, OK);
		waitOut(3, 1'b1, 3, cyc);
		chk(outs[3], 1'b1);
		@(posedge clk);
		linkDetect <= 1'b1;
		waitOut(3, 1'b0, 3, cyc);
		chk(outs[3], 1'b0);
		@(posedge clk);
		linkDetect <= 1'b0;
		waitOut(3, 1'b1, 3, cyc);
		chk(outs[3], 1'b1);
		@(posedge clk);
		setupButton <= 1'b1;
		@(posedge clk);
		setupButton <= 1'b0;
		waitOut(3, 1'b0, 3, cyc);
		chk(outs[3], 1'b0);
		waitOut(3, 1'b1, 200, cyc);
		chk(cyc >= 19 * TC && cyc <= 20 * TC + 4, 1);
		// a long sleep parks the sequence so the status word is stable
		axiWrite(sps_pkg::SLEEP_OFS, 32'hFFFF, OK);
		waitOut(1, 1'b0, 60, cyc);
		chk(cyc <= 60, 1);
		axiWrite(sps_pkg::STATUS_OFS, 32'h3F, OK);
		axiRead(sps_pkg::STATUS_OFS, 32'h12, OK);
		@(posedge clk);
		setupButton <= 1'b1;
		@(posedge clk);
		setupButton <= 1'b0;
		axiRead(sps_pkg::STATUS_OFS, 32'h22, OK);
	endtask : scEthernet

	task automatic complete_run();
		if (n_fail == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : complete_run

	initial
	begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		scReset();
		scModes();
		scSwitched();
		scNoSleep();
		scLowPower();
		scEthernet();
		complete_run();
	end

	// the whole sequence needs well under two thousand cycles
	initial
	begin
		repeat (5000) @(posedge clk);
		n_fail++;
		complete_run();
	end
endmodule : sps_sequencer_tb
